// *** rtl/suerr_pkg.sv ***
// Purpose: constants and types for the secondary uncorrectable error flag/suppress pair
// Assumes: 12-bit extended config offsets, 32-bit config data
// Notes: bit positions follow the flag register layout
package suerr_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] SUERR_FLAGS_OFS = 12'h12c;
    localparam logic [11:0] SUERR_SUPP_OFS = 12'h130;
    localparam logic [31:0] SUERR_FLAGS_RST = 32'h00000000;
    localparam logic [31:0] SUERR_SUPP_RST = 32'h000017a8;
    // implemented bits: flags 12,11,10,9,7,3,2; suppress 13..5,3..1
    localparam logic [31:0] SUERR_FLAGS_IMPL = 32'h00001e8c;
    localparam logic [31:0] SUERR_SUPP_IMPL = 32'h00003fee;
    localparam logic [31:0] SUERR_PTR_RST = 32'h00000000;
    // ==========================================================
    // field positions
    localparam int SUERR_BIT_SERR = 12;
    localparam int SUERR_BIT_PERR = 11;
    localparam int SUERR_BIT_DISCARD = 10;
    localparam int SUERR_BIT_ADDR_PAR = 9;
    localparam int SUERR_BIT_DATA_PAR = 7;
    localparam int SUERR_BIT_MABORT = 3;
    localparam int SUERR_BIT_TABORT = 2;
    localparam int SUERR_SYNC_STAGES = 3;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic serr;
        logic perr;
        logic discard;
        logic addr_par;
        logic data_par;
        logic mabort;
        logic tabort;
    } suerr_events_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } suerr_cfg_req_t;
endpackage : suerr_pkg

// *** rtl/suerr_regs.sv ***
// Purpose: secondary uncorrectable error flag and suppress registers
// Assumes: error events are one-cycle pulses from CLK_SYS logic
// Notes: reset pins are synchronised; register state clears on fundamental reset only
// Function
// - a flag bit clears only when software writes one to it; a zero leaves it.
// - a system-error assertion on the secondary bus sets flag bit 12.
// - a parity-error signal assertion on the secondary bus sets flag bit 11.
// - expiry of a secondary delayed transaction discard timer sets flag bit 10.
// - an address phase parity error of an upstream transaction sets flag bit 9.
// - an upstream write data parity error or parity-error on read data sets flag bit 7.
// - a master abort on a transaction the bridge initiated sets flag bit 3.
// - a target abort on a transaction the bridge initiated sets flag bit 2.
// - unimplemented flag bits read zero and ignore writes.
// - a suppressed error sets no flag, sends no message, loads no log, moves no pointer.
// - the suppress register resets to 0000_17a8.
// - suppress bits 13, 8, 6, 5 and 1 are plain storage with no effect.
// - suppress bits 31 to 14, 4 and 0 read zero and ignore writes.
// - all flag and suppress bits reset only on the active-low fundamental reset.
// - the five-bit first-error pointer holds the position of the first recorded error.
// - an unsuppressed error sends a fatal message if its severity is one, else nonfatal.
`timescale 1ns/10ps
module suerr_regs (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PLATFORM_RESET_N,
    input wire logic GLOBAL_RESET_N,
    input wire suerr_pkg::suerr_events_t SEC_ERR_EVENTS,
    input wire logic [31:0] SEVERITY,
    input wire suerr_pkg::suerr_cfg_req_t CFG_REQ,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RD_VALID,
    output logic ERR_FATAL_MSG,
    output logic ERR_NONFATAL_MSG,
    output logic HDR_LOG_LOAD,
    output logic [4:0] FIRST_ERR_PTR,
    output logic FUNDAMENTAL_RESET_N
);
    // ==========================================================
    // helpers
    function automatic logic [31:0] ev_vec(input suerr_pkg::suerr_events_t e);
        logic [31:0] v;
        v = 32'h00000000;
        v[suerr_pkg::SUERR_BIT_SERR] = e.serr;
        v[suerr_pkg::SUERR_BIT_PERR] = e.perr;
        v[suerr_pkg::SUERR_BIT_DISCARD] = e.discard;
        v[suerr_pkg::SUERR_BIT_ADDR_PAR] = e.addr_par;
        v[suerr_pkg::SUERR_BIT_DATA_PAR] = e.data_par;
        v[suerr_pkg::SUERR_BIT_MABORT] = e.mabort;
        v[suerr_pkg::SUERR_BIT_TABORT] = e.tabort;
        return v;
    endfunction : ev_vec

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    function automatic logic [4:0] top_index(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : top_index

    // ==========================================================
    // reset pin synchronisers
    logic [2:0] plat_sync;
    logic [2:0] glob_sync;
    logic plat_n;
    logic glob_n;
    wire fund_n = plat_n & glob_n;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            plat_sync <= 3'h0;
            glob_sync <= 3'h0;
        end else begin
            plat_sync <= {plat_sync[1:0], PLATFORM_RESET_N};
            glob_sync <= {glob_sync[1:0], GLOBAL_RESET_N};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            plat_n <= 1'b0;
            glob_n <= 1'b0;
        end else begin
            if (plat_sync[1] == plat_sync[2]) begin
                plat_n <= plat_sync[2];
            end
            if (glob_sync[1] == glob_sync[2]) begin
                glob_n <= glob_sync[2];
            end
        end
    end

    // ==========================================================
    // decode and next values
    logic [31:0] flags;
    logic [31:0] supp;
    logic first_seen;

    wire [31:0] bmask = lane_mask(CFG_REQ.be);
    wire wr_flags = CFG_REQ.wr && (CFG_REQ.addr == suerr_pkg::SUERR_FLAGS_OFS);
    wire wr_supp = CFG_REQ.wr && (CFG_REQ.addr == suerr_pkg::SUERR_SUPP_OFS);
    wire [31:0] clr = wr_flags ? (CFG_REQ.wdata & bmask) : 32'h00000000;
    // legacy suppress bits are outside the flag set, so they gate nothing
    wire [31:0] live = ev_vec(SEC_ERR_EVENTS) & ~supp & suerr_pkg::SUERR_FLAGS_IMPL;
    // set wins over clear
    wire [31:0] next_flags = ((flags & ~clr) | live) & suerr_pkg::SUERR_FLAGS_IMPL;
    wire [31:0] next_supp = wr_supp ?
        ((supp & ~bmask) | (CFG_REQ.wdata & bmask)) & suerr_pkg::SUERR_SUPP_IMPL : supp;
    wire any_live = |live;
    wire next_fatal = |(live & SEVERITY);
    wire next_nonfatal = |(live & ~SEVERITY);
    wire load_ptr = any_live && !first_seen;
    wire [31:0] next_rdata = !CFG_REQ.rd ? 32'h00000000 :
        (CFG_REQ.addr == suerr_pkg::SUERR_FLAGS_OFS) ? flags :
        (CFG_REQ.addr == suerr_pkg::SUERR_SUPP_OFS) ? supp : 32'h00000000;

    // ==========================================================
    // register state, fundamental reset only
    always_ff @(posedge CLK_SYS) begin
        if (!fund_n) begin
            flags <= suerr_pkg::SUERR_FLAGS_RST;
            supp <= suerr_pkg::SUERR_SUPP_RST;
            first_seen <= 1'b0;
            FIRST_ERR_PTR <= suerr_pkg::SUERR_PTR_RST[4:0];
        end else begin
            flags <= next_flags;
            supp <= next_supp;
            if (load_ptr) begin
                first_seen <= 1'b1;
                FIRST_ERR_PTR <= top_index(live);
            end
        end
    end

    // ==========================================================
    // message, log and read outputs
    always_ff @(posedge CLK_SYS) begin
        if (RST || !fund_n) begin
            ERR_FATAL_MSG <= 1'b0;
            ERR_NONFATAL_MSG <= 1'b0;
            HDR_LOG_LOAD <= 1'b0;
            CFG_RDATA <= 32'h00000000;
            CFG_RD_VALID <= 1'b0;
        end else begin
            ERR_FATAL_MSG <= next_fatal;
            ERR_NONFATAL_MSG <= next_nonfatal;
            HDR_LOG_LOAD <= any_live;
            CFG_RDATA <= next_rdata;
            CFG_RD_VALID <= CFG_REQ.rd;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            FUNDAMENTAL_RESET_N <= 1'b0;
        end else begin
            FUNDAMENTAL_RESET_N <= fund_n;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST || !fund_n);

    // bits that an event refreshes are left to the set checks
    chk_w1c_clear: assert property (
        (flags & ~$past(live)) == ($past(flags) & ~$past(clr) & ~$past(live)))
        else $error("flag clear does not follow written ones");
    chk_serr_sets: assert property (
        SEC_ERR_EVENTS.serr && !supp[12] |=> flags[12])
        else $error("system error did not set flag 12");
    chk_perr_sets: assert property (
        SEC_ERR_EVENTS.perr && !supp[11] |=> flags[11])
        else $error("parity signal did not set flag 11");
    chk_discard_sets: assert property (
        SEC_ERR_EVENTS.discard && !supp[10] |=> flags[10])
        else $error("discard expiry did not set flag 10");
    chk_addr_sets: assert property (
        SEC_ERR_EVENTS.addr_par && !supp[9] |=> flags[9])
        else $error("address parity did not set flag 9");
    chk_data_sets: assert property (
        SEC_ERR_EVENTS.data_par && !supp[7] |=> flags[7])
        else $error("data parity did not set flag 7");
    chk_mabort_sets: assert property (
        SEC_ERR_EVENTS.mabort && !supp[3] |=> flags[3])
        else $error("master abort did not set flag 3");
    chk_tabort_sets: assert property (
        SEC_ERR_EVENTS.tabort && !supp[2] |=> flags[2])
        else $error("target abort did not set flag 2");
    chk_flag_reserved: assert property (
        (flags & ~suerr_pkg::SUERR_FLAGS_IMPL) == 32'h00000000)
        else $error("reserved flag bit set");
    chk_mask_blocks: assert property (
        ((ev_vec(SEC_ERR_EVENTS) & ~supp) == 32'h00000000)
        |=> !ERR_FATAL_MSG && !ERR_NONFATAL_MSG && !HDR_LOG_LOAD
            && ((flags & ~$past(flags)) == 32'h00000000))
        else $error("suppressed error had an effect");
    chk_supp_reset: assert property (
        $rose(fund_n) |-> supp == suerr_pkg::SUERR_SUPP_RST)
        else $error("suppress reset value wrong");
    chk_legacy_store: assert property (
        wr_supp && CFG_REQ.be[1] |=> supp[13] == $past(CFG_REQ.wdata[13]))
        else $error("legacy suppress bit not stored");
    chk_supp_reserved: assert property (
        (supp & ~suerr_pkg::SUERR_SUPP_IMPL) == 32'h00000000)
        else $error("reserved suppress bit set");
    chk_fatal_msg: assert property (
        |(live & SEVERITY) |=> ERR_FATAL_MSG)
        else $error("fatal message missing");
    // pointer takes the position, then the capture stays armed off
    sequence ptr_loaded_s;
        (FIRST_ERR_PTR == top_index($past(live))) ##1 first_seen;
    endsequence
    chk_first_ptr: assert property (
        load_ptr |=> ptr_loaded_s)
        else $error("first error pointer not loaded");
    chk_flag_hold: assert property (
        !wr_flags |=> (flags & $past(flags)) == $past(flags))
        else $error("flag dropped without a clear");
endmodule : suerr_regs

// *** dv/suerr_far_end.sv ***
// Purpose: far-side bus agents that raise secondary error events
// Assumes: one request cycle from the bench gives one event pulse
// Notes: the pulse leaves on the edge after the request
`timescale 1ns/10ps
module suerr_far_end (
    input wire logic clk,
    input wire logic [6:0] raise,
    output suerr_pkg::suerr_events_t events
);
    always_ff @(posedge clk) begin
        events <= raise;
    end
endmodule : suerr_far_end

// *** dv/suerr_regs_tb.sv ***
// Purpose: self-checking bench for the secondary error flag/suppress pair
// Assumes: events come from the far-end model one edge after a request
// Notes: read data is checked by a monitor against a queue of expected words
`timescale 1ns/10ps
module suerr_regs_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic plat_n = 1'b1;
    logic glob_n = 1'b1;
    logic [6:0] raise = 7'h00;
    logic [31:0] sev = 32'h0;
    suerr_pkg::suerr_cfg_req_t req = '0;
    suerr_pkg::suerr_events_t events;
    logic [31:0] rdata;
    logic rd_valid, fatal, nonfatal, hdr_load, fundamental_reset_n_n;
    logic [4:0] ptr;
    logic [31:0] exp_q[$];
    logic [31:0] flags;
    int mismatches = 0;
    int tests_run = 0;
    int pos[7] = '{12, 11, 10, 9, 7, 3, 2};
    // ==========================================================
    // clock, design and far end
    always #2.5 clk_sys = ~clk_sys;
    suerr_far_end i_suerr_far_end (.clk(clk_sys), .raise(raise), .events(events));
    suerr_regs i_suerr_regs (
        .CLK_SYS(clk_sys), .RST(rst), .PLATFORM_RESET_N(plat_n), .GLOBAL_RESET_N(glob_n),
        .SEC_ERR_EVENTS(events), .SEVERITY(sev), .CFG_REQ(req), .CFG_RDATA(rdata),
        .CFG_RD_VALID(rd_valid), .ERR_FATAL_MSG(fatal), .ERR_NONFATAL_MSG(nonfatal),
        .HDR_LOG_LOAD(hdr_load), .FIRST_ERR_PTR(ptr), .FUNDAMENTAL_RESET_N(fundamental_reset_n_n)
    );
    // ==========================================================
    // tasks
    task automatic stop_test();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic cyc(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
        cyc();
        req = '0;
        cyc();
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
        exp_q.push_back(e);
        cyc();
        req = '0;
        cyc();
    endtask : rd
    task automatic fire(input logic [6:0] ev, input logic ef, input logic en, input logic eh);
        raise = ev;
        cyc();
        raise = 7'h00;
        cyc();
        chk({29'h0, fatal, nonfatal, hdr_load}, {29'h0, ef, en, eh});
    endtask : fire
    task automatic wait_fundamental_reset_n();
        for (int k = 0; k < 20 && fundamental_reset_n_n !== 1'b1; k++) cyc();
        cyc();
    endtask : wait_fundamental_reset_n
    // ==========================================================
    // read monitor
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxxxxxx);
        end
    end
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(90386));
        sev = $urandom();
        cyc(16);
        rst = 1'b0;
        wait_fundamental_reset_n();
        rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h0);
        rd(suerr_pkg::SUERR_SUPP_OFS, 32'h000017a8);
        rd(12'h200, 32'h0);
        wr(12'h200, 32'hffffffff);
        rd(suerr_pkg::SUERR_SUPP_OFS, 32'h000017a8);
        wr(suerr_pkg::SUERR_SUPP_OFS, 32'hffffffff);
        rd(suerr_pkg::SUERR_SUPP_OFS, 32'h00003fee);
        fire(7'h7f, 1'b0, 1'b0, 1'b0);
        rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h0);
        chk({27'h0, ptr}, 32'h0);
        wr(suerr_pkg::SUERR_SUPP_OFS, 32'h0);
        wr(suerr_pkg::SUERR_SUPP_OFS, 32'hffffffff, 4'h2);
        rd(suerr_pkg::SUERR_SUPP_OFS, 32'h00003f00);
        wr(suerr_pkg::SUERR_SUPP_OFS, 32'h0);
        flags = 32'h0;
        for (int i = 0; i < 7; i++) begin
            flags[pos[i]] = 1'b1;
            fire(7'h40 >> i, sev[pos[i]], !sev[pos[i]], 1'b1);
            rd(suerr_pkg::SUERR_FLAGS_OFS, flags);
        end
        chk({27'h0, ptr}, 32'h0000000c);
        wr(suerr_pkg::SUERR_FLAGS_OFS, 32'h0);
        rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h00001e8c);
        wr(suerr_pkg::SUERR_FLAGS_OFS, 32'h00000408);
        rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h00001a84);
        wr(suerr_pkg::SUERR_FLAGS_OFS, 32'hffffffff);
        rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h0);
        // event and clear of the same bit meet at one edge
        raise = 7'h40;
        cyc();
        raise = 7'h00;
        req = '{wr: 1'b1, rd: 1'b0, addr: suerr_pkg::SUERR_FLAGS_OFS, be: 4'hf, wdata: 32'h1000};
        cyc();
        req = '0;
        cyc();
        rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h00001000);
        for (int k = 0; k < 2; k++) begin
            wr(suerr_pkg::SUERR_SUPP_OFS, 32'h0);
            fire(7'h01, sev[2], !sev[2], 1'b1);
            if (k == 0) plat_n = 1'b0; else glob_n = 1'b0;
            cyc(6);
            chk({31'h0, fundamental_reset_n_n}, 32'h0);
            plat_n = 1'b1;
            glob_n = 1'b1;
            wait_fundamental_reset_n();
            rd(suerr_pkg::SUERR_FLAGS_OFS, 32'h0);
            rd(suerr_pkg::SUERR_SUPP_OFS, 32'h000017a8);
            chk({27'h0, ptr}, 32'h0);
        end
        cyc(3);
        chk(32'(exp_q.size()), 32'h0);
        stop_test();
    end
endmodule : suerr_regs_tb
